/* core/hmp_pkg.sv */
// Shared constants and types for the internal memory host port.
package hmp_pkg;
    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 14;
    localparam int BUS_W  = 16;
    localparam int PM_W   = 24;
    localparam int OVL_W  = 8;

    // ------------------------------------------------------------------
    // Latch word layout and memory spaces
    // ------------------------------------------------------------------
    localparam int   LATCH_OVL_BIT   = 15;
    localparam int   LATCH_SPACE_BIT = 14;
    localparam logic SPACE_PM        = 1'b0;
    localparam logic SPACE_DM        = 1'b1;

    // ------------------------------------------------------------------
    // Memory mapped registers in data memory
    // ------------------------------------------------------------------
    localparam logic [13:0] MMR_BASE       = 14'h3FE0;
    localparam logic [13:0] CTRL_ADDR      = 14'h3FE0;
    localparam logic [13:0] SYSREG_ADDR    = 14'h3FE7;
    localparam int          SHORT_READ_BIT = 14;
    localparam logic [15:0] SYSREG_RESET   = 16'h0000;
    localparam logic [7:0]  OVL_RESET      = 8'h00;
    localparam logic [13:0] ADDR_RESET     = 14'h0000;

    // ------------------------------------------------------------------
    // Boot straps, ordered C, B, A
    // ------------------------------------------------------------------
    localparam logic [2:0] BOOT_HOST_PORT = 3'h5;
    // Straps reset to zero in the filter, so the decision waits for them to settle.
    localparam logic [2:0] BOOT_SETTLE    = 3'h5;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ    = 200;
    localparam int STROBE_NS  = 20;
    localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int GAP_CYC    = 2 * STROBE_CYC;

    // ------------------------------------------------------------------
    // Host commands
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_LATCH = 2'b00,
        OP_READ  = 2'b01,
        OP_WRITE = 2'b10
    } hmp_op_e;
endpackage : hmp_pkg

/* core/hmp_if.sv */
// Link signals between the host end and the device end of the port.
`timescale 1ns/100ps
interface hmp_if;
    logic        port_select_n;
    logic        address_latch_strobe;
    logic        host_read_strobe_n;
    logic        host_write_strobe_n;
    logic        host_acknowledge_n;
    logic [15:0] host_bus_out;
    logic        host_bus_oe;
    logic [15:0] dev_bus_out;
    logic        dev_bus_oe;
    logic [15:0] host_addr_data_bus;

    // The device wins a clash; an undriven bus reads as pulled up.
    assign host_addr_data_bus = dev_bus_oe ? dev_bus_out :
                                host_bus_oe ? host_bus_out : 16'hFFFF;

    modport device (
        input  port_select_n,
        input  address_latch_strobe,
        input  host_read_strobe_n,
        input  host_write_strobe_n,
        input  host_addr_data_bus,
        output host_acknowledge_n,
        output dev_bus_out,
        output dev_bus_oe
    );

    modport host (
        output port_select_n,
        output address_latch_strobe,
        output host_read_strobe_n,
        output host_write_strobe_n,
        output host_bus_out,
        output host_bus_oe,
        input  host_acknowledge_n,
        input  host_addr_data_bus
    );
endinterface : hmp_if

/* core/hmp_device.sv */
// Device end of the internal memory host port with its on-chip memories.
`timescale 1ns/100ps
// What this block does
// - Host reaches memory, one cycle per word
// - Host cannot write memory mapped registers
// - Bit 15 set: bits 7:0 are overlay
// - Bit 15 clear: address 13:0, space bit 14
// - Host keeps both overlay fields zero
// - Sixteen-bit bus carries 24-bit program words
// - Strobes are asynchronous to the clock
// - Address increments after each whole word, so every second transaction for program memory
// - Host drives address only while acknowledged
// - Latch strobe falling edge captures the address
// - One cycle synchronises each request
// - Memory access takes one more cycle
// - Host checks acknowledge before starting
// - Host checks acknowledge for completion
// - Processor writes control register in data memory
// - Host cannot read back the address
// - System register bit 14 picks short-read timing
// - Straps C=1 B=0 A=1 select host boot
// - Boot holds execution until program word 0
module hmp_device #(
    parameter int MEM_DEPTH = 16384
) (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    // Link to the host
    hmp_if.device            link,
    // Processor memory port
    input  wire logic        core_req_i,
    input  wire logic        core_we_i,
    input  wire logic        core_space_i,
    input  wire logic [13:0] core_addr_i,
    input  wire logic [23:0] core_wdata_i,
    output logic      [23:0] core_rdata_o,
    // Boot straps and run control
    input  wire logic [2:0]  boot_mode_i,
    output logic             run_o
);
    localparam int AW = $clog2(MEM_DEPTH);
    localparam int SW = 7 + hmp_pkg::BUS_W;
    localparam int EW = 1 + hmp_pkg::ADDR_W + hmp_pkg::PM_W;
    localparam logic [SW-1:0] PIN_IDLE = {3'h0, 4'hB, 16'h0000};

    if (MEM_DEPTH < 2 || MEM_DEPTH > 16384 || (MEM_DEPTH & (MEM_DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("MEM_DEPTH must be a power of two from 2 to 16384.");
    end

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SYNC   = 2'b01,
        ST_ACCESS = 2'b10,
        ST_HOLD   = 2'b11
    } hmp_dev_state_e;

    function automatic logic is_mmr(input logic space, input logic [13:0] a);
        return (space == hmp_pkg::SPACE_DM) && (a >= hmp_pkg::MMR_BASE);
    endfunction : is_mmr

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [SW-1:0] s1_reg, s2_reg, s3_reg, pin_reg;
    wire  [SW-1:0] pin_raw = {boot_mode_i, link.port_select_n, link.address_latch_strobe,
                              link.host_read_strobe_n, link.host_write_strobe_n,
                              link.host_addr_data_bus};
    // A bit moves only once the second and third stages agree.
    wire  [SW-1:0] pin_next = ((s2_reg ~^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & pin_reg);

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s1_reg  <= PIN_IDLE;
            s2_reg  <= PIN_IDLE;
            s3_reg  <= PIN_IDLE;
            pin_reg <= PIN_IDLE;
        end
        else
        begin
            s1_reg  <= pin_raw;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            pin_reg <= pin_next;
        end
    end

    wire        sel  = ~pin_reg[19];
    wire        als  = pin_reg[18];
    wire        rd   = ~pin_reg[17];
    wire        wr   = ~pin_reg[16];
    wire [15:0] bus  = pin_reg[15:0];

    // ------------------------------------------------------------------
    // Address and overlay latch
    // ------------------------------------------------------------------
    hmp_dev_state_e state_reg;
    logic [13:0] addr_reg;
    logic        space_reg, half_reg, op_wr_reg, als_q_reg, sel_q_reg;
    logic [7:0]  ovl_reg, lo_reg;
    logic [15:0] sysreg_reg, hi_reg;

    wire latch_ev = (als_q_reg & ~als & sel) | (sel_q_reg & ~sel & als);
    wire core_ctrl_wr = core_req_i & core_we_i & (core_space_i == hmp_pkg::SPACE_DM)
                      & (core_addr_i == hmp_pkg::CTRL_ADDR);
    wire core_sys_wr  = core_req_i & core_we_i & (core_space_i == hmp_pkg::SPACE_DM)
                      & (core_addr_i == hmp_pkg::SYSREG_ADDR);
    wire [15:0] ld_word = latch_ev ? bus : core_wdata_i[15:0];
    wire        ld      = latch_ev | core_ctrl_wr;

    // ------------------------------------------------------------------
    // Memories, write buffer and access path
    // ------------------------------------------------------------------
    logic [23:0] pm_mem [MEM_DEPTH];
    logic [15:0] dm_mem [MEM_DEPTH];
    logic [EW-1:0] fifo_mem [2];
    logic        fifo_wp_reg, fifo_rp_reg;
    logic [1:0]  fifo_cnt_reg;

    wire         acc_pm   = (space_reg == hmp_pkg::SPACE_PM);
    wire         acc_mmr  = is_mmr(space_reg, addr_reg);
    wire         word_end = ~acc_pm | half_reg;
    wire [23:0]  pm_rd    = pm_mem[addr_reg[AW-1:0]];
    wire [15:0]  dm_rd    = dm_mem[addr_reg[AW-1:0]];
    wire [15:0]  rd_word  = acc_mmr ? 16'h0000 :
                            acc_pm ? (half_reg ? {8'h00, lo_reg} : pm_rd[23:8]) : dm_rd;
    wire [EW-1:0] push_ent = {space_reg, addr_reg,
                              acc_pm ? {hi_reg, bus[7:0]} : {8'h00, bus}};
    wire in_access = (state_reg == ST_ACCESS);
    wire push     = in_access & op_wr_reg & word_end & ~acc_mmr;
    wire push_rdy = (fifo_cnt_reg != 2'h2);
    wire pop_vld  = (fifo_cnt_reg != 2'h0);
    // Processor accesses win the write port; the buffer absorbs the stall.
    wire pop      = pop_vld & ~core_req_i;
    wire [EW-1:0] pop_ent = fifo_mem[fifo_rp_reg];

    wire core_mem_wr = core_req_i & core_we_i & ~is_mmr(core_space_i, core_addr_i);
    wire        mw_en    = core_mem_wr | pop;
    wire        mw_space = core_mem_wr ? core_space_i : pop_ent[EW-1];
    wire [13:0] mw_addr  = core_mem_wr ? core_addr_i : pop_ent[EW-2:hmp_pkg::PM_W];
    wire [23:0] mw_data  = core_mem_wr ? core_wdata_i : pop_ent[hmp_pkg::PM_W-1:0];
    wire [AW-1:0] core_idx = core_addr_i[AW-1:0];
    wire [23:0] core_rd_word =
        is_mmr(core_space_i, core_addr_i) ?
            ((core_addr_i == hmp_pkg::SYSREG_ADDR) ? {8'h00, sysreg_reg} : 24'h000000) :
        (core_space_i == hmp_pkg::SPACE_PM) ? pm_mem[core_idx] : {8'h00, dm_mem[core_idx]};

    always_ff @(posedge core_clk_i)
    begin
        if (mw_en && mw_space == hmp_pkg::SPACE_PM)
            pm_mem[mw_addr[AW-1:0]] <= mw_data;
        if (mw_en && mw_space == hmp_pkg::SPACE_DM)
            dm_mem[mw_addr[AW-1:0]] <= mw_data[15:0];
        if (push)
            fifo_mem[fifo_wp_reg] <= push_ent;
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fifo_wp_reg  <= 1'b0;
            fifo_rp_reg  <= 1'b0;
            fifo_cnt_reg <= 2'h0;
            core_rdata_o <= 24'h000000;
        end
        else
        begin
            fifo_wp_reg  <= fifo_wp_reg ^ push;
            fifo_rp_reg  <= fifo_rp_reg ^ pop;
            fifo_cnt_reg <= fifo_cnt_reg + {1'b0, push} - {1'b0, pop};
            if (core_req_i && !core_we_i)
                core_rdata_o <= core_rd_word;
        end
    end

    // ------------------------------------------------------------------
    // Port registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            addr_reg   <= hmp_pkg::ADDR_RESET;
            space_reg  <= hmp_pkg::SPACE_PM;
            ovl_reg    <= hmp_pkg::OVL_RESET;
            sysreg_reg <= hmp_pkg::SYSREG_RESET;
            half_reg   <= 1'b0;
            hi_reg     <= 16'h0000;
            lo_reg     <= 8'h00;
            als_q_reg  <= 1'b0;
            sel_q_reg  <= 1'b0;
        end
        else
        begin
            als_q_reg <= als;
            sel_q_reg <= sel;
            if (core_sys_wr)
                sysreg_reg <= core_wdata_i[15:0];
            if (ld && ld_word[hmp_pkg::LATCH_OVL_BIT])
                ovl_reg <= ld_word[7:0];
            if (ld && !ld_word[hmp_pkg::LATCH_OVL_BIT])
            begin
                addr_reg  <= ld_word[13:0];
                space_reg <= ld_word[hmp_pkg::LATCH_SPACE_BIT];
                half_reg  <= 1'b0;
            end
            else if (in_access)
            begin
                half_reg <= acc_pm & ~half_reg;
                if (word_end)
                    addr_reg <= addr_reg + 14'h0001;
                if (acc_pm && !half_reg)
                begin
                    hi_reg <= bus;
                    lo_reg <= pm_rd[7:0];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------------
    // The latched overlay never reaches the read path; only the address does.
    wire fast_short_read = sysreg_reg[hmp_pkg::SHORT_READ_BIT];

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_reg              <= ST_IDLE;
            op_wr_reg              <= 1'b0;
            link.host_acknowledge_n <= 1'b0;
            link.dev_bus_oe        <= 1'b0;
            link.dev_bus_out       <= 16'h0000;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                    if (sel && (rd || wr))
                    begin
                        state_reg               <= ST_SYNC;
                        op_wr_reg               <= wr;
                        link.host_acknowledge_n <= 1'b1;
                    end
                ST_SYNC:
                    // Reads wait for buffered writes so they see fresh data.
                    if (op_wr_reg ? push_rdy : !pop_vld)
                        state_reg <= ST_ACCESS;
                ST_ACCESS:
                begin
                    state_reg               <= ST_HOLD;
                    link.dev_bus_oe         <= ~op_wr_reg;
                    link.dev_bus_out        <= rd_word;
                    link.host_acknowledge_n <= ~op_wr_reg & ~fast_short_read;
                end
                ST_HOLD:
                begin
                    link.host_acknowledge_n <= 1'b0;
                    if (!sel || !(rd || wr))
                    begin
                        state_reg       <= ST_IDLE;
                        link.dev_bus_oe <= 1'b0;
                    end
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Boot hold
    // ------------------------------------------------------------------
    logic [2:0] boot_cnt_reg;

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            boot_cnt_reg <= 3'h0;
            run_o        <= 1'b0;
        end
        else if (boot_cnt_reg != hmp_pkg::BOOT_SETTLE)
        begin
            boot_cnt_reg <= boot_cnt_reg + 3'h1;
            if (boot_cnt_reg + 3'h1 == hmp_pkg::BOOT_SETTLE)
                run_o <= (pin_next[SW-1:SW-3] != hmp_pkg::BOOT_HOST_PORT);
        end
        else if (pop && pop_ent[EW-1] == hmp_pkg::SPACE_PM
                 && pop_ent[EW-2:hmp_pkg::PM_W] == 14'h0000)
            run_o <= 1'b1;
    end
endmodule : hmp_device

/* core/hmp_host.sv */
// Host end of the internal memory host port, driven by a simple command port.
`timescale 1ns/100ps
module hmp_host (
    // Clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             rst_i,
    // Link to the device
    hmp_if.host                   link,
    // Command port
    input  wire logic             cmd_valid_i,
    output logic                  cmd_ready_o,
    input  wire hmp_pkg::hmp_op_e cmd_op_i,
    input  wire logic [15:0]      cmd_data_i,
    // Read answers
    output logic                  rsp_valid_o,
    output logic      [15:0]      rsp_data_o
);
    localparam logic [7:0] ALS_END = 8'(hmp_pkg::STROBE_CYC - 1);
    localparam logic [7:0] LAT_END = 8'(2 * hmp_pkg::STROBE_CYC - 1);
    localparam logic [7:0] GAP_END = 8'(hmp_pkg::GAP_CYC - 1);

    if (hmp_pkg::GAP_CYC > 255 || hmp_pkg::STROBE_CYC < 1)
    begin : g_bad_timing
        $error("Strobe timing does not fit the 8-bit cycle counter.");
    end

    typedef enum logic [2:0] {
        H_IDLE  = 3'b000,
        H_WACK  = 3'b001,
        H_LATCH = 3'b010,
        H_XFER  = 3'b011,
        H_REL   = 3'b100
    } hmp_host_state_e;

    // ------------------------------------------------------------------
    // Synchronisers for acknowledge and bus
    // ------------------------------------------------------------------
    logic [16:0] s1_reg, s2_reg, s3_reg, in_reg;
    wire  [16:0] in_next = ((s2_reg ~^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & in_reg);
    wire         ack = ~in_reg[16];

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s1_reg <= 17'h1FFFF;
            s2_reg <= 17'h1FFFF;
            s3_reg <= 17'h1FFFF;
            in_reg <= 17'h1FFFF;
        end
        else
        begin
            s1_reg <= {link.host_acknowledge_n, link.host_addr_data_bus};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            in_reg <= in_next;
        end
    end

    // ------------------------------------------------------------------
    // Strobe sequencer
    // ------------------------------------------------------------------
    hmp_host_state_e  state_reg;
    hmp_pkg::hmp_op_e op_reg;
    logic [15:0]      data_reg;
    logic [7:0]       cnt_reg;
    logic             busy_seen_reg;

    // Overlay latches always carry zero overlay fields.
    wire [15:0] latch_word = data_reg[hmp_pkg::LATCH_OVL_BIT] ?
                             {1'b1, 15'h0000} : {1'b0, data_reg[14:0]};

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_reg                 <= H_IDLE;
            op_reg                    <= hmp_pkg::OP_LATCH;
            data_reg                  <= 16'h0000;
            cnt_reg                   <= 8'h00;
            busy_seen_reg             <= 1'b0;
            cmd_ready_o               <= 1'b1;
            rsp_valid_o               <= 1'b0;
            rsp_data_o                <= 16'h0000;
            link.port_select_n        <= 1'b1;
            link.address_latch_strobe <= 1'b0;
            link.host_read_strobe_n   <= 1'b1;
            link.host_write_strobe_n  <= 1'b1;
            link.host_bus_oe          <= 1'b0;
            link.host_bus_out         <= 16'h0000;
        end
        else
        begin
            rsp_valid_o <= 1'b0;
            cnt_reg     <= cnt_reg + 8'h01;
            case (state_reg)
                H_IDLE:
                    if (cmd_valid_i && cmd_ready_o)
                    begin
                        state_reg   <= H_WACK;
                        op_reg      <= cmd_op_i;
                        data_reg    <= cmd_data_i;
                        cmd_ready_o <= 1'b0;
                    end
                H_WACK:
                    if (ack)
                    begin
                        state_reg                 <= (op_reg == hmp_pkg::OP_LATCH) ?
                                                     H_LATCH : H_XFER;
                        cnt_reg                   <= 8'h00;
                        busy_seen_reg             <= 1'b0;
                        link.port_select_n        <= 1'b0;
                        link.address_latch_strobe <= (op_reg == hmp_pkg::OP_LATCH);
                        link.host_read_strobe_n   <= (op_reg != hmp_pkg::OP_READ);
                        link.host_write_strobe_n  <= (op_reg != hmp_pkg::OP_WRITE);
                        link.host_bus_oe          <= (op_reg != hmp_pkg::OP_READ);
                        link.host_bus_out         <= (op_reg == hmp_pkg::OP_LATCH) ?
                                                     latch_word : data_reg;
                    end
                H_LATCH:
                begin
                    if (cnt_reg == ALS_END)
                        link.address_latch_strobe <= 1'b0;
                    if (cnt_reg == LAT_END)
                    begin
                        state_reg          <= H_REL;
                        cnt_reg            <= 8'h00;
                        link.port_select_n <= 1'b1;
                        link.host_bus_oe   <= 1'b0;
                    end
                end
                H_XFER:
                    if (!ack)
                        busy_seen_reg <= 1'b1;
                    else if (busy_seen_reg)
                    begin
                        state_reg                <= H_REL;
                        cnt_reg                  <= 8'h00;
                        rsp_data_o               <= in_reg[15:0];
                        link.port_select_n       <= 1'b1;
                        link.host_read_strobe_n  <= 1'b1;
                        link.host_write_strobe_n <= 1'b1;
                        link.host_bus_oe         <= 1'b0;
                    end
                H_REL:
                    // The gap lets the device see the release before the next strobe.
                    if (cnt_reg == GAP_END)
                    begin
                        state_reg   <= H_IDLE;
                        cmd_ready_o <= 1'b1;
                        rsp_valid_o <= (op_reg == hmp_pkg::OP_READ);
                    end
                default:
                    state_reg <= H_IDLE;
            endcase
        end
    end
endmodule : hmp_host

/* tb/hmp_properties.sv */
// Link checks between the host end and the device end of the port.
`timescale 1ns/100ps
module hmp_properties (
    // Clock, reset and link signals
    input wire logic        core_clk_i,           input wire logic rst_i,
    input wire logic        port_select_n,        input wire logic address_latch_strobe,
    input wire logic        host_read_strobe_n,   input wire logic host_acknowledge_n,
    input wire logic [15:0] host_bus_out,         input wire logic host_bus_oe,
    input wire logic        dev_bus_oe
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    property p_wt; $fell(host_read_strobe_n) |-> !host_acknowledge_n; endproperty
    a_wt: assert property (p_wt) else $error("read began while busy");
    property p_bz; $fell(host_read_strobe_n) |-> ##[1:10] host_acknowledge_n; endproperty
    a_bz: assert property (p_bz) else $error("busy not shown");
    property p_dn; $rose(host_acknowledge_n) |-> ##[2:40] !host_acknowledge_n; endproperty
    a_dn: assert property (p_dn) else $error("access not done in time");
    property p_sl; host_acknowledge_n |-> !port_select_n; endproperty
    a_sl: assert property (p_sl) else $error("busy while idle");
    property p_hd; $rose(host_read_strobe_n) |-> !$past(host_acknowledge_n); endproperty
    a_hd: assert property (p_hd) else $error("read released early");
    property p_cl; !(dev_bus_oe && host_bus_oe); endproperty
    a_cl: assert property (p_cl) else $error("bus clash");
    property p_ov; address_latch_strobe && host_bus_out[15] |-> host_bus_out[14:8] == 7'h00;
    endproperty
    a_ov: assert property (p_ov) else $error("overlay word not clean");
    property p_la; $fell(address_latch_strobe) |-> host_bus_oe; endproperty
    a_la: assert property (p_la) else $error("latch on undriven bus");
    c_rd: cover property ($rose(dev_bus_oe));
    c_ov: cover property (address_latch_strobe && host_bus_out[15]);
    c_bz: cover property ($rose(host_acknowledge_n));
endmodule : hmp_properties

/* tb/host_internal_memory_port_tb.sv */
// Self-checking bench joining the host end and the device end.
`timescale 1ns/100ps
module host_internal_memory_port_tb;
    logic        core_clk_i = 1'b0, rst_i = 1'b1, core_req_i = 1'b0, cmd_valid_i = 1'b0;
    logic [23:0] core_wdata_i = 24'h000000;
    logic [15:0] cmd_data_i = 16'h0000, rsp_data_o, a, h;
    logic [1:0]  cmd_op_i = 2'h0;
    logic        run_o, cmd_ready_o, rsp_valid_o, core_we_i = 1'b1;
    logic [13:0] core_addr_i = hmp_pkg::SYSREG_ADDR;
    logic [23:0] core_rdata_o;
    logic [31:0] mem [int];
    int          n_fail = 0, compares = 0;
    hmp_if lk ();
    hmp_host hmp_host_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .link(lk),
        .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
        .cmd_op_i(hmp_pkg::hmp_op_e'(cmd_op_i)), .cmd_data_i(cmd_data_i), .rsp_data_o(rsp_data_o));
    hmp_device #(.MEM_DEPTH(64)) hmp_device_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .link(lk), .core_req_i(core_req_i), .core_we_i(core_we_i), .core_space_i(1'b1),
        .core_addr_i(core_addr_i), .core_wdata_i(core_wdata_i), .core_rdata_o(core_rdata_o),
        .boot_mode_i(3'h5), .run_o(run_o));
    hmp_properties hmp_properties_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .port_select_n(lk.port_select_n), .address_latch_strobe(lk.address_latch_strobe),
        .host_read_strobe_n(lk.host_read_strobe_n), .host_acknowledge_n(lk.host_acknowledge_n),
        .host_bus_out(lk.host_bus_out), .host_bus_oe(lk.host_bus_oe), .dev_bus_oe(lk.dev_bus_oe));
    initial forever #2.5 core_clk_i = ~core_clk_i;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        n_fail += (got !== exp);
        if (got !== exp) $display("[ERR] %0t got %h want %h", $time, got, exp);
    endtask : chk
    // The extra edge lets ready fall before it is polled again.
    task automatic cmd(input logic [1:0] op, input logic [15:0] d);
        {cmd_valid_i, cmd_op_i, cmd_data_i} = {1'b1, op, d};
        @(negedge core_clk_i);
        cmd_valid_i = 1'b0;
        @(negedge core_clk_i);
        for (int n = 0; n < 500 && cmd_ready_o !== 1'b1; n++) @(negedge core_clk_i);
    endtask : cmd
    task automatic wr(input logic dm, input int k, input logic [23:0] v);
        mem[k] = dm ? {16'h0000, v[15:0]} : {v[23:8], 8'h00, v[7:0]};
        cmd(2'h2, dm ? v[15:0] : v[23:8]);
        if (!dm) cmd(2'h2, {8'h00, v[7:0]});
    endtask : wr
    task automatic rd(input logic dm, input int k);
        cmd(2'h1, 16'h0000);
        h = rsp_data_o;
        chk(rsp_valid_o, 1'b1);
        if (!dm) cmd(2'h1, 16'h0000);
        chk(dm ? {16'h0000, h} : {h, rsp_data_o}, mem[k]);
    endtask : rd
    task automatic summarize();
        if (n_fail == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    initial
    begin
        #100000;
        n_fail++;
        summarize();
    end
    initial
    begin
        void'($urandom(46));
        repeat (4) @(negedge core_clk_i);
        rst_i = 1'b0;
        cmd(2'h0, 16'h0000);
        chk(run_o, 1'b0);
        for (int i = 0; i < 4; i++) wr(1'b0, i, 24'($urandom()));
        chk(run_o, 1'b1);
        cmd(2'h0, 16'h0000);
        for (int i = 0; i < 4; i++) rd(1'b0, i);
        core_wdata_i = 24'h004000;
        core_req_i = 1'b1;
        @(negedge core_clk_i);
        core_req_i = 1'b0;
        a = 16'($urandom_range(28));
        cmd(2'h0, 16'h4000 | a);
        cmd(2'h0, 16'h80FF);
        for (int i = 0; i < 3; i++) wr(1'b1, a + i + 16384, 24'($urandom()));
        cmd(2'h0, 16'h4000 | a);
        for (int i = 0; i < 3; i++) rd(1'b1, a + i + 16384);
        core_wdata_i = {8'h00, 16'h4000 | a};
        {core_addr_i, core_req_i} = {hmp_pkg::CTRL_ADDR, 1'b1};
        @(negedge core_clk_i);
        {core_we_i, core_addr_i} = {1'b0, a[13:0]};
        @(negedge core_clk_i);
        {core_req_i, core_we_i} = 2'b01;
        chk(core_rdata_o, mem[a + 16384]);
        rd(1'b1, a + 16384);
        cmd(2'h0, 16'h7FE0);
        wr(1'b1, -1, 24'h00A5A5);
        mem[-1] = 32'h00000000;
        cmd(2'h0, 16'h7FE0);
        rd(1'b1, -1);
        summarize();
    end
endmodule : host_internal_memory_port_tb
